// >>> hdl/imsbf_pkg.sv
// Constants for the imager scan sequencer and block formatter.
// Assumes a single 250 MHz system clock; all rates derive from it.
`default_nettype none
package imsbf_pkg;
  // ==========================================
  // Clock and timing
  localparam int CLK_HZ = 250000000;
  localparam int STEP_URAD = 8;
  localparam int SLEW_URAD_S = 174533;
  localparam int STEP_CYC = int'(64'(CLK_HZ) * STEP_URAD / SLEW_URAD_S);
  localparam int TURN_MS = 200;
  localparam int TURN_CYC = CLK_HZ / 1000 * TURN_MS;
  localparam int TURN_SEGS = 32;
  localparam int SOUTH_STEPS = 28;
  localparam int CAL_LEVELS = 16;
  // Bit clock as a phase accumulator: exact 2.6208 Mb/s
  localparam int BIT_RATE_HZ = 2620800;
  localparam logic [21:0] ACC_STEP = 22'(BIT_RATE_HZ / 100);
  localparam logic [21:0] ACC_MOD = 22'(CLK_HZ / 100);
  // ==========================================
  // Block format
  localparam int SMP_W = 10;
  localparam int WORDS = 48;
  localparam int VIS_N = 8;
  localparam int IR_N = 7;
  localparam int VIS_PER_BLK = 4;
  localparam int TAIL_BLKS = 3;
  localparam int TELEM_BLKS = 39;
  localparam logic [9:0] SYNC_WORD = 10'h3E5;
  localparam logic [9:0] FILL_WORD = 10'h155;
  localparam logic [9:0] CRAFT_ID = 10'h0A1; // arbitrary value
  localparam logic [9:0] INSTR_ID = 10'h0B2; // arbitrary value
  localparam logic [5:0] W_ID = 6'h01;
  localparam logic [5:0] W_MOTION = 6'h02;
  localparam logic [5:0] W_SERVO = 6'h03;
  localparam logic [5:0] W_VIS0 = 6'h04;
  localparam logic [5:0] W_IR0 = 6'h24;
  // Quarter cosine, cos(k*pi/32)*127, k = 0..16
  localparam logic [7:0] COS_TAB [0:16] = '{8'h7F, 8'h7E, 8'h7D, 8'h7A, 8'h75, 8'h70,
    8'h6A, 8'h62, 8'h5A, 8'h51, 8'h47, 8'h3C, 8'h31, 8'h25, 8'h19, 8'h0C, 8'h00};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SLEW_EW = 3'b001,
    ST_SLEW_NS = 3'b010,
    ST_LINE = 3'b011,
    ST_TURN = 3'b100,
    ST_DWELL = 3'b101
  } imsbf_state_type;

  typedef enum logic [2:0] {
    BLK_FILL = 3'b000,
    BLK_HEAD = 3'b001,
    BLK_ACT = 3'b010,
    BLK_TRAIL = 3'b011,
    BLK_TELEM = 3'b100
  } imsbf_blk_type;
endpackage : imsbf_pkg
`default_nettype wire

// >>> hdl/imsbf_top.sv
// Scan mirror sequencer and 480-bit block formatter with serial output.
// Assumes commands and detector samples come from logic on i_mclk.
//
// Functional notes
// - Scan starts from a command carrying frame start and end locations.
// - Location is inductosyn cycle plus increment; increment selects sine/cosine.
// - East-west increment 8 urad mechanical, 16 optical; north-south 8 both.
// - Slew by single increments at fast rate; east-west before north-south.
// - Line scan uses slew step rate and increment size.
// - At line end run 0.2 s turnaround, 32 cosine velocity steps.
// - Each turnaround steps north-south 28 increments south.
// - Repeat line, turnaround, south step until southern limit.
// - Excursions reuse slew and position logic; by command or subprogram. Here started by the i_excur_go command only.
// - Consecutive lines alternate scan direction.
// - Infrared sampled 5460/s, visible 21840/s during lines.
// - Per block: visible detectors four samples, infrared one.
// - Coordinate origin is zero cycle, zero increment, northwest corner.
// - Every sample is a 10-bit code.
// - Blocks are 480 bits as 48 words of 10 bits.
// - Start-of-line from sequencer synchronises formatter block sequence.
// - Header block after start-of-line: ids, status, attitude, coordinates, fill.
// - Active blocks: sync, ids, motion compensation, servo error, samples.
// - Three more active blocks after line end.
// - Then trailer block like header, then 39 telemetry blocks.
// - All data multiplexed and sent as one serial stream.
// - Serial rate 2.6208 Mb/s, 5460 blocks per second.
// - During space look, step calibration through sixteen levels.
`default_nettype none
module imsbf_top #(
  parameter int CYC_W = 8,
  parameter int INC_W = 8,
  parameter int STEP_CYC = imsbf_pkg::STEP_CYC,
  parameter int TURN_CYC = imsbf_pkg::TURN_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_scan_go,
  input wire logic [CYC_W+INC_W-1:0] i_start_ew,
  input wire logic [CYC_W+INC_W-1:0] i_start_ns,
  input wire logic [CYC_W+INC_W-1:0] i_end_ew,
  input wire logic [CYC_W+INC_W-1:0] i_end_ns,
  input wire logic i_excur_go,
  input wire logic [CYC_W+INC_W-1:0] i_excur_ew,
  input wire logic [CYC_W+INC_W-1:0] i_excur_ns,
  input wire logic [imsbf_pkg::VIS_N*imsbf_pkg::SMP_W-1:0] i_vis_data,
  input wire logic [imsbf_pkg::IR_N*imsbf_pkg::SMP_W-1:0] i_ir_data,
  input wire logic [imsbf_pkg::SMP_W-1:0] i_motion,
  input wire logic [imsbf_pkg::SMP_W-1:0] i_servo_err,
  input wire logic [imsbf_pkg::SMP_W-1:0] i_status,
  input wire logic [imsbf_pkg::SMP_W-1:0] i_attitude,
  input wire logic [imsbf_pkg::SMP_W-1:0] i_telem,
  output logic [CYC_W-1:0] o_ew_cyc,
  output logic [INC_W-1:0] o_ew_inc,
  output logic [CYC_W-1:0] o_ns_cyc,
  output logic [INC_W-1:0] o_ns_inc,
  output logic [7:0] o_vel_code,
  output logic o_busy,
  output logic o_sol,
  output logic o_vis_strobe,
  output logic o_ir_strobe,
  output logic o_cal_en,
  output logic [3:0] o_cal_level,
  output logic o_ser_bit,
  output logic o_bit_strobe
);
  import imsbf_pkg::*;
  localparam int PW = CYC_W + INC_W;
  localparam int SEG_CYC = TURN_CYC / TURN_SEGS;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  function automatic logic [PW-1:0] step_to(input logic [PW-1:0] pos, input logic [PW-1:0] tgt);
    if (pos < tgt) return pos + PW'(1);
    else if (pos > tgt) return pos - PW'(1);
    else return pos;
  endfunction : step_to

  // ==========================================
  // Scan sequencer
  imsbf_state_type state_reg;
  logic [PW-1:0] ew_reg, ns_reg, tgt_ew_reg, tgt_ns_reg, ret_ew_reg, ret_ns_reg;
  logic [PW-1:0] start_ew_reg, end_ew_reg, end_ns_reg;
  logic leg_reg, scanning_reg, exc_reg, exc_pend_reg;
  logic [PW-1:0] exc_ew_reg, exc_ns_reg;
  logic [31:0] step_cnt_reg, sub_cnt_reg;
  logic [4:0] seg_reg;
  logic line_end_reg;
  logic [PW-1:0] line_tgt;
  logic step_tick, seg_roll;

  assign step_tick = step_cnt_reg == 32'(STEP_CYC - 1);
  assign seg_roll = sub_cnt_reg == 32'(SEG_CYC - 1);
  assign line_tgt = leg_reg ? start_ew_reg : end_ew_reg;

  // Step pacing: one increment per period in slews and lines
  always_ff @(posedge i_mclk) begin
    if (i_rst || !(state_reg inside {ST_SLEW_EW, ST_SLEW_NS, ST_LINE}) || step_tick) begin
      step_cnt_reg <= '0;
    end else begin
      step_cnt_reg <= step_cnt_reg + 32'd1;
    end
  end

  // Turnaround and space-look segment timing
  always_ff @(posedge i_mclk) begin
    if (i_rst || !(state_reg inside {ST_TURN, ST_DWELL})) begin
      sub_cnt_reg <= '0;
      seg_reg <= '0;
    end else if (seg_roll) begin
      sub_cnt_reg <= '0;
      seg_reg <= seg_reg + 5'd1;
    end else begin
      sub_cnt_reg <= sub_cnt_reg + 32'd1;
    end
  end

  // Excursion request latch; a new request beats the clear
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      exc_pend_reg <= 1'b0;
      exc_ew_reg <= '0;
      exc_ns_reg <= '0;
    end else if (i_excur_go) begin
      exc_pend_reg <= 1'b1;
      exc_ew_reg <= i_excur_ew;
      exc_ns_reg <= i_excur_ns;
    end else if ((state_reg == ST_IDLE && !i_scan_go) ||
                 (state_reg == ST_TURN && seg_roll && seg_reg == 5'd31)) begin
      exc_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      ew_reg <= '0;
      ns_reg <= '0;
      tgt_ew_reg <= '0;
      tgt_ns_reg <= '0;
      ret_ew_reg <= '0;
      ret_ns_reg <= '0;
      start_ew_reg <= '0;
      end_ew_reg <= '0;
      end_ns_reg <= '0;
      leg_reg <= 1'b0;
      scanning_reg <= 1'b0;
      exc_reg <= 1'b0;
      o_sol <= 1'b0;
      line_end_reg <= 1'b0;
    end else begin
      o_sol <= 1'b0;
      line_end_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (i_scan_go) begin
            start_ew_reg <= i_start_ew;
            end_ew_reg <= i_end_ew;
            end_ns_reg <= i_end_ns;
            tgt_ew_reg <= i_start_ew;
            tgt_ns_reg <= i_start_ns;
            leg_reg <= 1'b0;
            scanning_reg <= 1'b1;
            state_reg <= ST_SLEW_EW;
          end else if (exc_pend_reg) begin
            ret_ew_reg <= ew_reg;
            ret_ns_reg <= ns_reg;
            tgt_ew_reg <= exc_ew_reg;
            tgt_ns_reg <= exc_ns_reg;
            exc_reg <= 1'b1;
            state_reg <= ST_SLEW_EW;
          end
        end
        ST_SLEW_EW: begin
          if (ew_reg == tgt_ew_reg) state_reg <= ST_SLEW_NS;
          else if (step_tick) ew_reg <= step_to(ew_reg, tgt_ew_reg);
        end
        ST_SLEW_NS: begin
          if (ns_reg == tgt_ns_reg) begin
            if (exc_reg) begin
              state_reg <= ST_DWELL;
            end else if (scanning_reg) begin
              state_reg <= ST_LINE;
              o_sol <= 1'b1;
            end else begin
              state_reg <= ST_IDLE;
            end
          end else if (step_tick) begin
            ns_reg <= step_to(ns_reg, tgt_ns_reg);
          end
        end
        ST_LINE: begin
          if (ew_reg == line_tgt) begin
            line_end_reg <= 1'b1;
            if (ns_reg >= end_ns_reg) begin
              scanning_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= ST_TURN;
            end
          end else if (step_tick) begin
            ew_reg <= step_to(ew_reg, line_tgt);
          end
        end
        ST_TURN: begin
          if (seg_roll && seg_reg < 5'(SOUTH_STEPS)) ns_reg <= ns_reg + PW'(1);
          if (seg_roll && seg_reg == 5'd31) begin
            leg_reg <= !leg_reg;
            if (exc_pend_reg) begin
              ret_ew_reg <= ew_reg;
              ret_ns_reg <= ns_reg;
              tgt_ew_reg <= exc_ew_reg;
              tgt_ns_reg <= exc_ns_reg;
              exc_reg <= 1'b1;
              state_reg <= ST_SLEW_EW;
            end else begin
              state_reg <= ST_LINE;
              o_sol <= 1'b1;
            end
          end
        end
        ST_DWELL: begin
          if (seg_roll && seg_reg == 5'd31) begin
            exc_reg <= 1'b0;
            tgt_ew_reg <= ret_ew_reg;
            tgt_ns_reg <= ret_ns_reg;
            state_reg <= ST_SLEW_EW;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign o_ew_cyc = ew_reg[PW-1:INC_W];
  assign o_ew_inc = ew_reg[INC_W-1:0];
  assign o_ns_cyc = ns_reg[PW-1:INC_W];
  assign o_ns_inc = ns_reg[INC_W-1:0];

  // Velocity profile and calibration staircase
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_vel_code <= '0;
      o_cal_en <= 1'b0;
      o_cal_level <= '0;
      o_busy <= 1'b0;
    end else begin
      o_busy <= state_reg != ST_IDLE;
      o_cal_en <= state_reg == ST_DWELL;
      o_cal_level <= seg_reg[4:1];
      if (state_reg != ST_TURN) o_vel_code <= COS_TAB[0];
      else if (seg_reg <= 5'd16) o_vel_code <= COS_TAB[seg_reg];
      else o_vel_code <= 8'h00 - COS_TAB[5'd0 - seg_reg];
    end
  end

  // ==========================================
  // Bit timing and block framing
  logic [21:0] acc_reg;
  logic [22:0] acc_sum;
  logic bit_tick;
  logic [3:0] bit_reg;
  logic [5:0] word_reg, blk_cnt_reg, nidx;
  logic blk_end, sol_pend_reg, end_pend_reg, tail_reg;
  imsbf_blk_type blk_reg;

  assign acc_sum = {1'b0, acc_reg} + {1'b0, ACC_STEP};
  assign bit_tick = acc_sum >= {1'b0, ACC_MOD};
  assign blk_end = bit_tick && bit_reg == 4'd9 && word_reg == 6'(WORDS - 1);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      acc_reg <= '0;
      bit_reg <= '0;
      word_reg <= '0;
    end else begin
      acc_reg <= bit_tick ? 22'(acc_sum - {1'b0, ACC_MOD}) : acc_sum[21:0];
      if (bit_tick) begin
        bit_reg <= bit_reg == 4'd9 ? 4'd0 : bit_reg + 4'd1;
        if (bit_reg == 4'd9) word_reg <= blk_end ? 6'd0 : word_reg + 6'd1;
      end
    end
  end

  // Block sequence; a line event in the boundary cycle is kept
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      blk_reg <= BLK_FILL;
      blk_cnt_reg <= '0;
      sol_pend_reg <= 1'b0;
      end_pend_reg <= 1'b0;
      tail_reg <= 1'b0;
    end else begin
      if (o_sol) sol_pend_reg <= 1'b1;
      else if (blk_end) sol_pend_reg <= 1'b0;
      if (line_end_reg) end_pend_reg <= 1'b1;
      else if (blk_end) end_pend_reg <= 1'b0;
      if (blk_end) begin
        blk_cnt_reg <= '0;
        tail_reg <= 1'b0;
        if (sol_pend_reg) begin
          blk_reg <= BLK_HEAD;
        end else begin
          unique case (blk_reg)
            BLK_HEAD: blk_reg <= BLK_ACT;
            BLK_ACT: begin
              if (tail_reg && blk_cnt_reg == 6'(TAIL_BLKS)) begin
                blk_reg <= BLK_TRAIL;
              end else if (tail_reg || end_pend_reg) begin
                tail_reg <= 1'b1;
                blk_cnt_reg <= blk_cnt_reg + 6'd1;
              end
            end
            BLK_TRAIL: begin
              blk_reg <= BLK_TELEM;
              blk_cnt_reg <= 6'd1;
            end
            BLK_TELEM: begin
              if (blk_cnt_reg == 6'(TELEM_BLKS)) blk_reg <= BLK_FILL;
              else blk_cnt_reg <= blk_cnt_reg + 6'd1;
            end
            BLK_FILL: blk_reg <= BLK_FILL;
            default: blk_reg <= BLK_FILL;
          endcase
        end
      end
    end
  end

  // ==========================================
  // Sample capture; one block of latency so output never mixes blocks
  logic [SMP_W-1:0] cap_vis [0:VIS_N*VIS_PER_BLK-1];
  logic [SMP_W-1:0] out_vis [0:VIS_N*VIS_PER_BLK-1];
  logic [SMP_W-1:0] cap_ir [0:IR_N-1];
  logic [SMP_W-1:0] out_ir [0:IR_N-1];
  logic [1:0] vis_k_reg;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_vis_strobe <= 1'b0;
      o_ir_strobe <= 1'b0;
      vis_k_reg <= '0;
    end else begin
      o_vis_strobe <= bit_tick && bit_reg == 4'd0 && blk_reg == BLK_ACT &&
                      word_reg inside {6'd0, 6'd12, 6'd24, 6'd36};
      o_ir_strobe <= bit_tick && bit_reg == 4'd0 && blk_reg == BLK_ACT &&
                     word_reg == 6'd0;
      if (bit_tick && bit_reg == 4'd0) vis_k_reg <= 2'(word_reg / 6'd12);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (o_vis_strobe) begin
      for (int d = 0; d < VIS_N; d++) begin
        cap_vis[vis_k_reg*VIS_N+d] <= i_vis_data[d*SMP_W +: SMP_W];
      end
    end
    if (o_ir_strobe) begin
      for (int d = 0; d < IR_N; d++) cap_ir[d] <= i_ir_data[d*SMP_W +: SMP_W];
    end
    if (blk_end) begin
      out_vis <= cap_vis;
      out_ir <= cap_ir;
    end
  end

  // ==========================================
  // Word multiplexer and serializer
  logic [9:0] word_next, shift_reg;

  assign nidx = word_reg + 6'd1;

  always_comb begin
    word_next = FILL_WORD;
    if (nidx == W_ID) begin
      word_next = {1'b0, blk_reg, blk_cnt_reg};
    end else begin
      unique case (blk_reg)
        BLK_HEAD, BLK_TRAIL: begin
          unique case (nidx)
            6'd2: word_next = CRAFT_ID;
            6'd3: word_next = INSTR_ID;
            6'd4: word_next = i_status;
            6'd5: word_next = i_attitude;
            6'd6: word_next = 10'(ew_reg >> INC_W);
            6'd7: word_next = 10'(ew_reg[INC_W-1:0]);
            6'd8: word_next = 10'(ns_reg >> INC_W);
            6'd9: word_next = 10'(ns_reg[INC_W-1:0]);
            default: word_next = FILL_WORD;
          endcase
        end
        BLK_ACT: begin
          if (nidx == W_MOTION) word_next = i_motion;
          else if (nidx == W_SERVO) word_next = i_servo_err;
          else if (nidx >= W_VIS0 && nidx < W_IR0) word_next = out_vis[5'(nidx - W_VIS0)];
          else if (nidx >= W_IR0 && nidx < W_IR0 + 6'(IR_N))
            word_next = out_ir[3'(nidx - W_IR0)];
        end
        BLK_TELEM: begin
          if (nidx == 6'd2) word_next = i_telem;
        end
        default: word_next = FILL_WORD;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      shift_reg <= SYNC_WORD;
      o_ser_bit <= 1'b0;
      o_bit_strobe <= 1'b0;
    end else begin
      o_bit_strobe <= bit_tick;
      if (bit_tick) begin
        o_ser_bit <= shift_reg[4'd9 - bit_reg];
        if (bit_reg == 4'd9) shift_reg <= blk_end ? SYNC_WORD : word_next;
      end
    end
  end

  // ==========================================
  // Checks
  a_slew_order: assert property (state_reg == ST_SLEW_NS |-> ew_reg == tgt_ew_reg)
    else $error("north-south slew began before east-west finished");
  a_single_step: assert property ($changed(ew_reg) && state_reg != ST_IDLE |->
    (ew_reg == $past(ew_reg) + PW'(1)) || (ew_reg == $past(ew_reg) - PW'(1)))
    else $error("east-west moved by more than one increment");
  // Outside slews the only north-south motion is the southward turnaround step
  a_turn_south: assert property ($changed(ns_reg) && state_reg != ST_SLEW_NS |->
    state_reg == ST_TURN && ns_reg == $past(ns_reg) + PW'(1))
    else $error("north-south moved outside turnaround");
  a_dir_alternate: assert property ($past(state_reg) == ST_TURN && state_reg == ST_LINE |->
    leg_reg != $past(leg_reg))
    else $error("line direction did not alternate");
  a_sol_pulse: assert property (o_sol |-> state_reg == ST_LINE ##1 !o_sol)
    else $error("start-of-line not a single pulse at line entry");
  a_word_range: assert property (word_reg < 6'(WORDS) && bit_reg < 4'd10)
    else $error("block word or bit counter out of range");
  a_bit_spacing: assert property (bit_tick |=> !bit_tick [*8])
    else $error("bit ticks too close");
  a_tail_blocks: assert property (blk_end && blk_reg == BLK_ACT && !sol_pend_reg &&
    blk_cnt_reg != 6'(TAIL_BLKS) |=> blk_reg == BLK_ACT)
    else $error("trailer before three tail blocks");
  a_telem_count: assert property (blk_reg == BLK_TELEM |-> blk_cnt_reg <= 6'(TELEM_BLKS))
    else $error("more than the telemetry block count");
  a_cal_stair: assert property (o_cal_en && $changed(o_cal_level) && $past(o_cal_en) |->
    o_cal_level == $past(o_cal_level) + 4'd1)
    else $error("calibration level skipped");
endmodule : imsbf_top
`default_nettype wire

// >>> bench/imsbf_rx_model.sv
// Model of the receiver that takes the serial block stream.
// Assumes the first bit after reset is bit 9 of word 0 of a block.
`default_nettype none
module imsbf_rx_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_bit,
  input wire logic i_strobe,
  output logic [9:0] o_word,
  output logic [5:0] o_widx,
  output logic [7:0] o_blk,
  output logic o_wvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Word assembly
  logic [8:0] sh_reg;
  logic [3:0] nb_reg;
  logic [5:0] w_reg;
  logic [7:0] b_reg;
  always_ff @(posedge i_mclk) begin
    o_wvalid <= 1'b0;
    if (i_rst) begin
      nb_reg <= 4'h0;
      w_reg <= 6'h00;
      b_reg <= 8'h00;
      o_blk <= 8'h00;
    end else if (i_strobe) begin
      sh_reg <= {sh_reg[7:0], i_bit};
      if (nb_reg == 4'h9) begin
        // First bit received is the word's top bit
        nb_reg <= 4'h0;
        o_word <= {sh_reg, i_bit};
        o_widx <= w_reg;
        o_blk <= b_reg;
        o_wvalid <= 1'b1;
        w_reg <= (w_reg == 6'h2F) ? 6'h00 : w_reg + 6'h01;
        if (w_reg == 6'h2F) begin
          b_reg <= b_reg + 8'h01;
        end
      end else begin
        nb_reg <= nb_reg + 4'h1;
      end
    end
  end
endmodule : imsbf_rx_model
`default_nettype wire

// >>> bench/imsbf_top_bench.sv
// Self-checking bench: frame scan, excursion, first two serial blocks.
// Assumes the design package and the receiver model are compiled first.
`default_nettype none
module imsbf_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Short counts keep two whole blocks under 100k cycles
  localparam int STEPC = 20;
  localparam int TURNC = 320;
  logic i_mclk, i_rst, scan_go, excur_go, busy, sol, cal_en, ser_bit, bit_stb, rx_valid;
  logic vis_stb, ir_stb;
  logic [15:0] st_ew, st_ns, en_ew, en_ns, ex_ew, ex_ns, ew, ns;
  logic [9:0] status, att, rx_word;
  logic [7:0] ew_cyc, ew_inc, ns_cyc, ns_inc, vel, rx_blk;
  logic [3:0] cal_lvl;
  logic [5:0] rx_idx;
  logic [9:0] words [0:1][0:47];
  int miscompares = 0;
  int check_count = 0;
  int gap = 0;
  int nstb = 0;
  int nsmp = 0;
  assign ew = {ew_cyc, ew_inc};
  assign ns = {ns_cyc, ns_inc};
  // ==========================================
  // Design and receiver
  imsbf_top #(.STEP_CYC(STEPC), .TURN_CYC(TURNC)) DUT (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_scan_go(scan_go), .i_start_ew(st_ew),
    .i_start_ns(st_ns), .i_end_ew(en_ew), .i_end_ns(en_ns), .i_excur_go(excur_go),
    .i_excur_ew(ex_ew), .i_excur_ns(ex_ns), .i_vis_data({8{10'h2C7}}),
    .i_ir_data({7{10'h1D4}}), .i_motion(10'h0F0), .i_servo_err(10'h00F),
    .i_status(status), .i_attitude(att), .i_telem(10'h3C3), .o_ew_cyc(ew_cyc),
    .o_ew_inc(ew_inc), .o_ns_cyc(ns_cyc), .o_ns_inc(ns_inc), .o_vel_code(vel),
    .o_busy(busy), .o_sol(sol), .o_vis_strobe(vis_stb), .o_ir_strobe(ir_stb), .o_cal_en(cal_en),
    .o_cal_level(cal_lvl), .o_ser_bit(ser_bit), .o_bit_strobe(bit_stb));
  imsbf_rx_model RX (.i_mclk(i_mclk), .i_rst(i_rst), .i_bit(ser_bit),
    .i_strobe(bit_stb), .o_word(rx_word), .o_widx(rx_idx), .o_blk(rx_blk),
    .o_wvalid(rx_valid));
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  // ==========================================
  // Checking helpers
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic limit(input int i, input int lim);
    if (i >= lim) begin
      chk(16'hDEAD, 16'h0000);
      report_and_stop;
    end
  endtask : limit
  // Monitor on the falling edge, where registered outputs have settled
  always @(negedge i_mclk) begin
    gap = gap + 1;
    if (vis_stb !== 1'b0 || ir_stb !== 1'b0) nsmp++;
    if (bit_stb === 1'b1) begin
      if (nstb > 0 && gap != 95 && gap != 96) chk(gap[15:0], 16'h005F);
      nstb++;
      gap = 0;
    end
    if (rx_valid === 1'b1 && rx_blk < 8'h02) words[rx_blk[0]][rx_idx] <= rx_word;
  end
  // ==========================================
  // Scenarios
  task automatic t_scan;
    int i, ph, last, tend, len;
    logic [15:0] pew, ns1;
    logic neg;
    ph = 0;
    last = 0;
    tend = 0;
    pew = ew;
    ns1 = 16'h0000;
    neg = 1'b0;
    st_ew = 16'h0003;
    st_ns = 16'h0002;
    en_ew = 16'h0008;
    en_ns = 16'h0004;
    scan_go = 1'b1;
    @(negedge i_mclk);
    scan_go = 1'b0;
    @(negedge i_mclk);
    chk(busy, 1'b1);
    for (i = 0; i < 4000 && !(ph == 2 && busy === 1'b0); i++) begin
      if (ph == 0 && ns !== 16'h0000 && ew !== st_ew) chk(ew, st_ew);
      if (ew !== pew) begin
        if (ph > 0 && last > 0) chk(16'(i - last), 16'(STEPC));
        if (ph > 0) chk(ew, ph == 1 ? pew + 16'h0001 : pew - 16'h0001);
        last = i;
        tend = i;
        pew = ew;
      end
      if (sol === 1'b1) begin
        if (ph == 0) begin
          chk(ew, st_ew);
          chk(ns, st_ns);
          ns1 = ns;
        end else begin
          chk(ns - ns1, 16'h001C);
          len = i - tend;
          chk(16'(len >= TURNC && len <= TURNC + 3), 16'h0001);
        end
        ph++;
        last = 0;
      end
      if (vel[7] === 1'b1) neg = 1'b1;
      @(negedge i_mclk);
    end
    limit(i, 4000);
    chk(ew, st_ew);
    chk(ns, 16'h001E);
    chk(neg, 1'b1);
    chk(vel, 16'h007F);
  endtask : t_scan
  task automatic t_excur;
    int i;
    logic [15:0] mask;
    logic seen;
    mask = 16'h0000;
    seen = 1'b0;
    ex_ew = 16'h0001;
    ex_ns = 16'h0001;
    excur_go = 1'b1;
    @(negedge i_mclk);
    excur_go = 1'b0;
    for (i = 0; i < 6000 && !(seen && busy === 1'b0); i++) begin
      if (cal_en === 1'b1) begin
        if (!seen) chk(ew, ex_ew);
        if (!seen) chk(ns, ex_ns);
        seen = 1'b1;
        mask[cal_lvl] = 1'b1;
      end
      @(negedge i_mclk);
    end
    limit(i, 6000);
    chk(mask, 16'hFFFF);
    chk(ew, 16'h0003);
    chk(ns, 16'h001E);
  endtask : t_excur
  task automatic t_serial;
    int i;
    for (i = 0; i < 95000 && !(rx_blk === 8'h01 && rx_idx === 6'h09); i++) begin
      @(negedge i_mclk);
    end
    limit(i, 95000);
    repeat (2) @(negedge i_mclk);
    chk(words[0][0], imsbf_pkg::SYNC_WORD);
    chk(words[1][0], imsbf_pkg::SYNC_WORD);
    chk(words[0][1][9:6], 4'h0);
    chk(words[1][1][9:6], 4'h1);
    chk(words[1][2], imsbf_pkg::CRAFT_ID);
    chk(words[1][3], imsbf_pkg::INSTR_ID);
    chk(words[1][4], status);
    chk(words[1][5], att);
    chk(words[1][7], 16'h0003);
    chk(words[1][9], 16'h001E);
    chk(16'(nstb), 16'h0244);
    chk(16'(nsmp), 16'h0000);
  endtask : t_serial
  // ==========================================
  // Main sequence
  initial begin
    i_rst = 1'b1;
    scan_go = 1'b0;
    excur_go = 1'b0;
    {st_ew, st_ns, en_ew, en_ns, ex_ew, ex_ns} = '0;
    status = 10'h2AA;
    att = 10'h133;
    repeat (8) @(negedge i_mclk);
    i_rst = 1'b0;
    t_scan;
    t_excur;
    t_serial;
    report_and_stop;
  end
endmodule : imsbf_top_bench
`default_nettype wire
